/* bench/ucs_chk.sv */
/* Assertions on the bus and event ports of the serial core.
   Assumes binding to the core; one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module ucs_chk (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events
  input wire logic rx_timeout,
  input wire logic frame_end,
  input wire logic wake
);
  // Words sit at 0x00, 0x1c and 0x20 to 0x48; anything else is a hole.
  wire mapped = paddr == 8'h00 || paddr == 8'h1c ||
    (paddr >= 8'h20 && paddr <= 8'h48 && paddr[1:0] == 2'h0);
  wire sleep_wr = psel && pwrite && paddr == 8'h38;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait; $rose(psel && penable) |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("answer not after one wait");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("answer held too long");
  property p_err; pready |-> pslverr == !mapped; endproperty
  a_err: assert property (p_err) else $error("error flag wrong for address");
  property p_wzero; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wzero: assert property (p_wzero) else $error("read data on a write");
  property p_tout; rx_timeout |=> !rx_timeout; endproperty
  a_tout: assert property (p_tout) else $error("timeout pulse too long");
  property p_fend; frame_end |=> !frame_end; endproperty
  a_fend: assert property (p_fend) else $error("frame end pulse too long");
  property p_whold; wake && !sleep_wr |=> wake; endproperty
  a_whold: assert property (p_whold) else $error("wake dropped alone");
  property p_wclr; pready && sleep_wr |=> !wake; endproperty
  a_wclr: assert property (p_wclr) else $error("wake not cleared");
endmodule // ucs_chk
bind ucs_uart_config_status_core ucs_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .rx_timeout, .frame_end, .wake);
`default_nettype wire

/* bench/ucs_peer.sv */
/* Peer serial device: sends frames on rxd, samples frames on txd.
   Assumes bt pclk cycles per bit and an idle-high line. */
`timescale 1ns/100ps
`default_nettype none
module ucs_peer (
  // Line side
  input wire logic pclk,
  input wire logic txd,
  output logic rxd
);
  int bt = 4;
  // The line idles high, so nothing is mistaken for a start bit.
  initial rxd = 1'b1;
  // Sends n frame bits first bit first; the last bit is a stop bit.
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (bt) @(posedge pclk);
    end
  endtask
  // Waits for a start bit, then samples each bit near its middle.
  task automatic recv(input int n, output logic [10:0] f);
    f = '1;
    while (txd !== 1'b0) @(posedge pclk);
    repeat (bt / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (bt) @(posedge pclk);
    end
  endtask
endmodule // ucs_peer
`default_nettype wire

/* bench/ucs_uart_config_status_core_tb.sv */
/* Self-checking bench: bus master, frame model and peer device.
   Assumes the checker binds itself to the core. */
`timescale 1ns/100ps
`default_nettype none
`include "ucs_defines.vh"
module ucs_uart_config_status_core_tb;
  logic pclk, presetn, psel, penable, pwrite, ref_tick, txd, rts_n;
  logic pready, pslverr, serr, rxd, tfe, rff, dtr, ccd;
  logic ccd_seen = 1'b0;
  logic [7:0] paddr, d;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] rnd;
  logic [10:0] fr;
  logic [7:0] ra [5] = '{8'h20, 8'h24, 8'h3c, 8'h40, 8'h48};
  logic [31:0] rv [5] = '{`UCS_R_CONF0, `UCS_R_CONF1, `UCS_R_SWFC, `UCS_R_IDLE, `UCS_R_CMD};
  int n_fail = 0, tests_run = 0, cyc = 0;
  ucs_uart_config_status_core u_ucs_uart_config_status_core (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ref_tick,
    .clkdiv(20'h3), .rxd, .cts_n(1'b0), .dsr_n(1'b0), .txd, .rts_n, .dtr_n(dtr),
    .txfifo_empty_raw(tfe), .rxfifo_full_raw(rff), .rx_timeout(), .frame_end(),
    .cmd_char_det(ccd), .wake());
  ucs_peer u_ucs_peer (.pclk, .txd, .rxd);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected frame: start, data first bit first, parity, then ones.
  function automatic logic [10:0] frm(input logic [7:0] v, input int len, pen, odd);
    logic [10:0] f;
    logic p;
    f = '1;
    f[0] = 1'b0;
    p = odd[0];
    for (int i = 0; i < len; i++) begin
      f[i + 1] = v[i];
      p = p ^ v[i];
    end
    if (pen) f[len + 1] = p;
    return f;
  endfunction
  // Clock of 5 ns.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Random reference ticks; the cycle ceiling cuts a hang well past the run.
  always @(posedge pclk) begin
    rnd <= lfsr(rnd);
    ref_tick <= rnd[0];
    cyc <= cyc + 1;
    if (ccd) ccd_seen <= 1'b1;
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic waitrx(input int c);
    int k;
    k = 0;
    do apb(0, 8'h1c, 0); while (rdat[10:0] != c && ++k < 100);
    chk(rdat[10:0], c);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    ref_tick = 1'b0;
    rnd = 16'd31433;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, idle status and line levels, then a hole in the map.
    foreach (ra[i]) begin
      apb(0, ra[i], 0);
      chk(rdat, rv[i]);
    end
    apb(0, 8'h1c, 0);
    chk(rdat & 32'hf7fff7ff, 0);
    chk({txd, rts_n, tfe, rff}, 4'b1010);
    apb(0, 8'h04, 0);
    chk(serr, 1);
    // Every data length with parity off, even and odd.
    for (int m = 0; m < 12; m++) begin
      apb(1, 8'h20, 32'h00100001 | (m % 4) << 22 | (m > 3) << 24 | (m > 7) << 25);
      d = rnd[7:0];
      fork
        u_ucs_peer.recv(7 + m % 4 + (m > 3), fr);
        apb(1, 8'h00, {24'h0, d});
      join
      chk({21'h0, fr}, frm(d, 5 + m % 4, m > 3, m > 7));
    end
    // Loopback on the reference tick returns two bytes in order.
    apb(1, 8'h20, (`UCS_R_CONF0 & ~32'h1) | 32'h10000);
    apb(1, 8'h00, 32'h5a);
    apb(1, 8'h00, 32'hc3);
    waitrx(2);
    apb(0, 8'h00, 0);
    chk(rdat[7:0], 8'h5a);
    apb(0, 8'h00, 0);
    chk(rdat[7:0], 8'hc3);
    // A peer byte over zero thresholds drops RTS and raises the full flag.
    apb(1, 8'h20, `UCS_R_CONF0);
    apb(1, 8'h24, 32'h1000);
    apb(1, 8'h28, 0);
    u_ucs_peer.send({2'b11, 8'h55, 1'b0}, 10);
    waitrx(1);
    chk({rts_n, rff, tfe}, 3'b111);
    apb(0, 8'h30, 0);
    chk(rdat[9:0], 10);
    // The receive FIFO stays empty while its reset bit is set.
    apb(1, 8'h20, `UCS_R_CONF0 | 32'h100);
    u_ucs_peer.send({2'b11, 8'h3c, 1'b0}, 10);
    waitrx(0);
    chk({rts_n, rff}, 2'b00);
    // After a long idle the command character is stored and later flagged.
    apb(1, 8'h20, `UCS_R_CONF0);
    repeat (48) @(posedge pclk);
    u_ucs_peer.send({2'b11, 8'h2b, 1'b0}, 10);
    waitrx(1);
    apb(0, 8'h00, 0);
    chk(rdat[7:0], 8'h2b);
    // A send-Xon request goes out as the Xon character and clears itself.
    fork
      u_ucs_peer.recv(10, fr);
      apb(1, 8'h34, 32'h2);
    join
    chk({21'h0, fr}, frm(`UCS_R_SWFC >> 8, 8, 0, 0));
    apb(0, 8'h34, 0);
    chk(rdat[1:0], 0);
    // Edge activity set wake; a write to the sleep register clears it.
    apb(0, 8'h38, 0);
    chk(rdat[31], 1);
    apb(1, 8'h38, 32'h3ff);
    apb(0, 8'h38, 0);
    chk(rdat[31], 0);
    // Inverted transmit and terminal-ready lines idle low one cycle after the write.
    apb(1, 8'h20, `UCS_R_CONF0 | 32'h22);
    @(posedge pclk);
    chk({txd, dtr}, 0);
    chk(ccd_seen, 1);
    finish_test();
  end
endmodule // ucs_uart_config_status_core_tb
`default_nettype wire

/* include/ucs_defines.vh */
/*
  Register map, field positions, reset values, state codes and sizes
  for the serial port configuration and status core.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef UCS_DEFINES_VH
`define UCS_DEFINES_VH
// Register byte addresses.
`define UCS_A_DATA 8'h00
`define UCS_A_STAT 8'h1c
`define UCS_A_CONF0 8'h20
`define UCS_A_CONF1 8'h24
`define UCS_A_LOWP 8'h28
`define UCS_A_HIGHP 8'h2c
`define UCS_A_EDGE 8'h30
`define UCS_A_FLOW 8'h34
`define UCS_A_SLEEP 8'h38
`define UCS_A_SWFC 8'h3c
`define UCS_A_IDLE 8'h40
`define UCS_A_RS485 8'h44
`define UCS_A_CMD 8'h48
// Line and frame configuration fields.
`define UCS_CLKSEL 0
`define UCS_TXINV 1
`define UCS_RXINV 2
`define UCS_RTSINV 3
`define UCS_CTSINV 4
`define UCS_DTRINV 5
`define UCS_DSRINV 6
`define UCS_TXRST 7
`define UCS_RXRST 8
`define UCS_IRDA 9
`define UCS_IRTXEN 10
`define UCS_IRRXINV 11
`define UCS_IRTXINV 12
`define UCS_IRWCTL 13
`define UCS_IRDPLX 14
`define UCS_TXFLOW 15
`define UCS_LOOP 16
`define UCS_BRK 17
`define UCS_SWRTS 18
`define UCS_SWDTR 19
`define UCS_STOP 21:20
`define UCS_BITN 23:22
`define UCS_PEN 24
`define UCS_PODD 25
// Threshold fields.
`define UCS_FULLT 7:0
`define UCS_EMPTT 15:8
`define UCS_FLOWT 22:16
`define UCS_FLOWEN 23
`define UCS_TOUT 30:24
`define UCS_TOUTEN 31
// Flow character fields.
`define UCS_XOFFC 7:0
`define UCS_XONC 15:8
`define UCS_XOFFT 23:16
`define UCS_XONT 31:24
// Idle and break fields.
`define UCS_RXIDLE 7:0
`define UCS_TXIDLE 17:8
`define UCS_BRKN 25:18
// Multidrop fields.
`define UCS_MDEN 0
`define UCS_DLA 1
`define UCS_DLB 2
`define UCS_TXRX 3
`define UCS_RXBY 4
`define UCS_TXDLY 8:5
`define UCS_RXDLY 12:9
// Command character fields.
`define UCS_CCHR 7:0
`define UCS_PRE 15:8
`define UCS_POST 23:16
// Flow control bits and the sleep register edge threshold.
`define UCS_SXOFF 0
`define UCS_SXON 1
`define UCS_FXOFF 2
`define UCS_FXON 3
`define UCS_STRIP 4
`define UCS_SWEN 5
`define UCS_ACTT 9:0
// Write masks and reset values.
`define UCS_M_CONF0 32'h03ffffff
`define UCS_M_IDLE 32'h03ffffff
`define UCS_M_RS485 32'h00001fff
`define UCS_M_CMD 32'h00ffffff
`define UCS_R_CONF0 32'h00d00001
`define UCS_R_CONF1 32'h00001060
`define UCS_R_SWFC 32'h60201113
`define UCS_R_IDLE 32'h00280a08
`define UCS_R_CMD 32'h000a0a2b
// Sizes and special values.
`define UCS_DEPTH 8'h80
`define UCS_AW 7
`define UCS_STOP_1P5 2'h2
`define UCS_IR_BIT11 4'ha
`define UCS_MAXCNT 20'hfffff
// Readable state codes.
`define UCS_C_IDLE 4'h0
`define UCS_C_STRT 4'h1
`define UCS_C_DAT0 4'h2
`define UCS_C_PRTY 4'ha
`define UCS_C_STP1 4'hb
`define UCS_C_STP2 4'hc
`define UCS_C_TDL0 4'hd
`define UCS_C_TDL1 4'he
`define UCS_C_RDL1 4'hd
`endif

/* logic/ucs_uart_config_status_core.v */
/*
  Serial port core: frame engine, two byte FIFOs, flow control, break,
  multidrop, infrared, baud measurement, sleep wake and idle detection.
  Assumes an APB master, a bit divider value and reference tick from
  outside, and serial inputs already synchronous to pclk.
*/
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "ucs_defines.vh"
module ucs_uart_config_status_core (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Bit timing
  input wire ref_tick,
  input wire [19:0] clkdiv,
  // Serial lines
  input wire rxd,
  input wire cts_n,
  input wire dsr_n,
  output reg txd,
  output reg rts_n,
  output reg dtr_n,
  // Event outputs
  output reg txfifo_empty_raw,
  output reg rxfifo_full_raw,
  output reg rx_timeout,
  output reg frame_end,
  output reg cmd_char_det,
  output reg wake
);
  localparam [7:0] S_IDLE = 8'h01, S_STRT = 8'h02, S_DAT = 8'h04, S_PRTY = 8'h08;
  localparam [7:0] S_STP1 = 8'h10, S_STP2 = 8'h20, S_DL0 = 8'h40, S_DL1 = 8'h80;
  reg [31:0] conf0_reg, conf1_reg, swfc_reg, idle_reg, rs485_reg, cmd_reg;
  reg [5:0] flow_reg;
  reg [9:0] actt_reg;
  reg [31:0] rdata;
  reg hit;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire sclk_en = conf0_reg[`UCS_CLKSEL] | ref_tick;
  wire md = rs485_reg[`UCS_MDEN];
  wire [2:0] dlast = {1'b0, conf0_reg[`UCS_BITN]} + 3'h4;
  wire cts_act = ~(cts_n ^ conf0_reg[`UCS_CTSINV]);
  wire dsr_act = ~(dsr_n ^ conf0_reg[`UCS_DSRINV]);

  // Byte FIFOs: index 0 transmits, index 1 receives.
  wire [1:0] f_push, f_pop, f_flush;
  wire [15:0] f_din, f_dout, f_cnt;
  assign f_flush = {conf0_reg[`UCS_RXRST], conf0_reg[`UCS_TXRST]};
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_fifo
      reg [7:0] mem [0:`UCS_DEPTH-1];
      reg [`UCS_AW-1:0] wp, rp;
      reg [7:0] cnt;
      // Flush holds both pointers at zero for as long as the bit stays set.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wp <= {`UCS_AW{1'b0}};
          rp <= {`UCS_AW{1'b0}};
          cnt <= 8'h00;
        end else if (f_flush[g]) begin
          wp <= {`UCS_AW{1'b0}};
          rp <= {`UCS_AW{1'b0}};
          cnt <= 8'h00;
        end else begin
          if (f_push[g]) wp <= wp + 1'b1;
          if (f_pop[g]) rp <= rp + 1'b1;
          case ({f_push[g], f_pop[g]})
            2'b10: cnt <= cnt + 8'h01;
            2'b01: cnt <= cnt - 8'h01;
            default: cnt <= cnt;
          endcase
        end
      end
      // Storage has no reset; only the pointers define its contents.
      always @(posedge pclk) begin
        if (f_push[g] & ~f_flush[g]) mem[wp] <= f_din[g*8 +: 8];
      end
      assign f_dout[g*8 +: 8] = mem[rp];
      assign f_cnt[g*8 +: 8] = cnt;
    end
  endgenerate
  wire [7:0] tx_cnt = f_cnt[7:0];
  wire [7:0] rx_cnt = f_cnt[15:8];

  // Transmitter state.
  reg [7:0] tst;
  reg [7:0] tsh, tbrk;
  reg [2:0] tbit;
  reg [3:0] fpos;
  reg [19:0] tcnt;
  reg [10:0] tgap;
  reg tpar, tprev, brk_armed, hold, xoff_sent;
  wire tstop15 = (tst == S_STP2) && (conf0_reg[`UCS_STOP] == `UCS_STOP_1P5);
  wire [19:0] tlim = tstop15 ? {1'b0, clkdiv[19:1]} : clkdiv;
  wire tend = sclk_en && (tcnt >= tlim);
  wire [10:0] gap_lim = {1'b0, idle_reg[`UCS_TXIDLE]} +
    (md ? {7'h00, rs485_reg[`UCS_TXDLY]} : 11'h000);
  reg tv_raw, tv;
  // Line value before encoding; break drives zeros while idle.
  always @* begin
    case (tst)
      S_IDLE: tv_raw = (tbrk == 8'h00);
      S_STRT: tv_raw = 1'b0;
      S_DAT: tv_raw = tsh[0];
      S_PRTY: tv_raw = tpar ^ conf0_reg[`UCS_PODD];
      default: tv_raw = 1'b1;
    endcase
    tv = tv_raw;
    if (conf0_reg[`UCS_IRDA] && (tst != S_IDLE) && (fpos == `UCS_IR_BIT11))
      tv = conf0_reg[`UCS_IRWCTL] & tprev;
  end
  // Infrared sends a zero as a quarter-bit pulse; the pulse is longer
  // than the usual 3/16 only to save a multiplier.
  wire ir_pulse = conf0_reg[`UCS_IRTXEN] & ~tv & (tcnt < {2'b00, clkdiv[19:2]});
  wire tline = conf0_reg[`UCS_IRDA] ? (ir_pulse ^ conf0_reg[`UCS_IRTXINV]) :
    (tv ^ conf0_reg[`UCS_TXINV]);

  // Receiver state.
  reg [7:0] rst_s;
  reg [7:0] rsh;
  reg [2:0] rbit;
  reg [19:0] rcnt;
  reg [9:0] ridle;
  reg rpar, perr, ferr, rin_q, got, pre_ok, cand;
  wire lb = conf0_reg[`UCS_LOOP] | (conf0_reg[`UCS_IRDA] & conf0_reg[`UCS_IRDPLX]) |
    (md & rs485_reg[`UCS_TXRX]);
  wire rin = lb ? tv : conf0_reg[`UCS_IRDA] ? ~(rxd ^ conf0_reg[`UCS_IRRXINV]) :
    (rxd ^ conf0_reg[`UCS_RXINV]);
  wire redge = rin ^ rin_q;
  wire rstop15 = (rst_s == S_STP2) && (conf0_reg[`UCS_STOP] == `UCS_STOP_1P5);
  wire [19:0] rlim = (rst_s == S_STRT) ? ({1'b0, clkdiv[19:1]} +
    (md ? {16'h0000, rs485_reg[`UCS_RXDLY]} : 20'h00000)) :
    rstop15 ? {1'b0, clkdiv[19:1]} : clkdiv;
  wire rtick = sclk_en && (rcnt >= rlim);
  wire [7:0] rbyte = rsh >> (3'h7 - dlast);
  wire rdone = rtick && (rst_s == S_STP1);
  wire is_xoff = rbyte == swfc_reg[`UCS_XOFFC];
  wire is_xon = rbyte == swfc_reg[`UCS_XONC];
  wire fchar = flow_reg[`UCS_SWEN] & (is_xoff | is_xon);
  wire strip = fchar & flow_reg[`UCS_STRIP];

  // Transmit start gating: flow chars bypass the received Xoff hold.
  wire tx_cts_ok = ~(conf0_reg[`UCS_TXFLOW] & ~cts_act);
  wire tx_bus_ok = ~(md & ~rs485_reg[`UCS_RXBY] & (rst_s != S_IDLE));
  wire fl_req = flow_reg[`UCS_SXOFF] | flow_reg[`UCS_SXON];
  wire t_go = tend && (tst == S_IDLE) && (tbrk == 8'h00) && (tgap >= gap_lim) &&
    tx_cts_ok && tx_bus_ok && (fl_req || ((tx_cnt != 8'h00) && ~hold));
  wire t_data = t_go & ~fl_req;
  assign f_pop[0] = t_data;
  assign f_push[0] = wr && (paddr == `UCS_A_DATA) && (tx_cnt != `UCS_DEPTH);
  assign f_din[7:0] = pwdata[7:0];
  assign f_push[1] = rdone && ~strip && (rx_cnt != `UCS_DEPTH);
  assign f_din[15:8] = rbyte;
  assign f_pop[1] = acc && ~pwrite && (paddr == `UCS_A_DATA) && (rx_cnt != 8'h00);
  wire tx_after_stop = md & (rs485_reg[`UCS_DLA] | rs485_reg[`UCS_DLB]);

  // Transmit frame sequencer.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tst <= S_IDLE;
      tsh <= 8'h00;
      tbit <= 3'h0;
      fpos <= 4'h0;
      tcnt <= 20'h00000;
      tgap <= 11'h000;
      tbrk <= 8'h00;
      tpar <= 1'b0;
      tprev <= 1'b1;
      brk_armed <= 1'b0;
    end else begin
      if (sclk_en) tcnt <= tend ? 20'h00000 : tcnt + 20'h00001;
      if (tend) begin
        tprev <= tv;
        if (tst != S_IDLE) fpos <= fpos + 4'h1;
        case (tst)
          S_IDLE: begin
            if (tbrk != 8'h00) tbrk <= tbrk - 8'h01;
            else if (tgap < gap_lim) tgap <= tgap + 11'h001;
            if (t_go) begin
              tst <= S_STRT;
              fpos <= 4'h0;
              tbit <= 3'h0;
              tpar <= 1'b0;
              tsh <= flow_reg[`UCS_SXOFF] ? swfc_reg[`UCS_XOFFC] :
                flow_reg[`UCS_SXON] ? swfc_reg[`UCS_XONC] : f_dout[7:0];
              if (t_data) brk_armed <= conf0_reg[`UCS_BRK];
            end
          end
          S_STRT: tst <= S_DAT;
          S_DAT: begin
            tpar <= tpar ^ tsh[0];
            tsh <= {1'b0, tsh[7:1]};
            tbit <= tbit + 3'h1;
            if (tbit == dlast) tst <= conf0_reg[`UCS_PEN] ? S_PRTY : S_STP1;
          end
          S_PRTY: tst <= S_STP1;
          S_STP1, S_STP2, S_DL0, S_DL1: begin
            if (tst == S_STP1 && conf0_reg[`UCS_STOP] >= `UCS_STOP_1P5) tst <= S_STP2;
            else if (tst != S_DL0 && tst != S_DL1 && tx_after_stop)
              tst <= (md & rs485_reg[`UCS_DLA]) ? S_DL0 : S_DL1;
            else if (tst == S_DL0 && rs485_reg[`UCS_DLB]) tst <= S_DL1;
            else begin
              tst <= S_IDLE;
              tgap <= 11'h000;
              if (brk_armed && tx_cnt == 8'h00) begin
                tbrk <= idle_reg[`UCS_BRKN];
                brk_armed <= 1'b0;
              end
            end
          end
          default: tst <= S_IDLE;
        endcase
      end
    end
  end

  // Receive frame sequencer with idle, timeout and command tracking.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_s <= S_IDLE;
      rsh <= 8'h00;
      rbit <= 3'h0;
      rcnt <= 20'h00000;
      ridle <= 10'h000;
      {rpar, perr, ferr, got, pre_ok, cand} <= 6'h00;
      rin_q <= 1'b1;
      {rx_timeout, frame_end, cmd_char_det} <= 3'h0;
    end else begin
      rin_q <= rin;
      rx_timeout <= 1'b0;
      frame_end <= 1'b0;
      cmd_char_det <= 1'b0;
      if (sclk_en) rcnt <= rtick ? 20'h00000 : rcnt + 20'h00001;
      if (rst_s == S_IDLE && rin_q && !rin) begin
        rst_s <= S_STRT;
        rcnt <= 20'h00000;
        pre_ok <= ridle >= {2'b00, cmd_reg[`UCS_PRE]};
        cand <= 1'b0;
        ridle <= 10'h000;
      end else if (rst_s == S_IDLE) begin
        if (rtick && ridle != 10'h3ff) ridle <= ridle + 10'h001;
        if (rtick && got && ridle == {2'b00, idle_reg[`UCS_RXIDLE]}) begin
          frame_end <= 1'b1;
          got <= 1'b0;
        end
        if (rtick && conf1_reg[`UCS_TOUTEN] && rx_cnt != 8'h00 &&
            ridle == {3'h0, conf1_reg[`UCS_TOUT]})
          rx_timeout <= 1'b1;
        if (cand && ridle >= {2'b00, cmd_reg[`UCS_POST]}) begin
          cmd_char_det <= 1'b1;
          cand <= 1'b0;
        end
      end else if (rtick) begin
        case (rst_s)
          S_STRT: begin
            rst_s <= rin ? S_IDLE : S_DAT;
            rbit <= 3'h0;
            rpar <= 1'b0;
          end
          S_DAT: begin
            rsh <= {rin, rsh[7:1]};
            rpar <= rpar ^ rin;
            rbit <= rbit + 3'h1;
            if (rbit == dlast) rst_s <= conf0_reg[`UCS_PEN] ? S_PRTY : S_STP1;
          end
          S_PRTY: begin
            perr <= (rpar ^ conf0_reg[`UCS_PODD]) != rin;
            rst_s <= S_STP1;
          end
          S_STP1: begin
            ferr <= ~rin;
            got <= 1'b1;
            cand <= pre_ok && (rbyte == cmd_reg[`UCS_CCHR]);
            if (!conf0_reg[`UCS_PEN]) perr <= 1'b0;
            if (conf0_reg[`UCS_STOP] >= `UCS_STOP_1P5) rst_s <= S_STP2;
            else rst_s <= (md & rs485_reg[`UCS_DLB]) ? S_DL1 : S_IDLE;
          end
          S_STP2: rst_s <= (md & rs485_reg[`UCS_DLB]) ? S_DL1 : S_IDLE;
          default: rst_s <= S_IDLE;
        endcase
      end
    end
  end

  // Baud measurement counted in serial clock enables, sleep wake counted in line edges.
  reg [19:0] pcnt, lmin, hmin;
  reg [9:0] ecnt, wcnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt <= 20'h00000;
      lmin <= `UCS_MAXCNT;
      hmin <= `UCS_MAXCNT;
      ecnt <= 10'h000;
      wcnt <= 10'h000;
      wake <= 1'b0;
    end else begin
      if (redge) begin
        pcnt <= 20'h00000;
        if (rin && pcnt < lmin) lmin <= pcnt;
        if (!rin && pcnt < hmin) hmin <= pcnt;
        ecnt <= ecnt + 10'h001;
      end else if (sclk_en && pcnt != `UCS_MAXCNT) begin
        pcnt <= pcnt + 20'h00001;
      end
      if (wr && paddr == `UCS_A_LOWP) begin
        lmin <= `UCS_MAXCNT;
        hmin <= `UCS_MAXCNT;
        ecnt <= 10'h000;
      end
      // A write to the sleep register rearms; a new edge still counts.
      if (wr && paddr == `UCS_A_SLEEP) wcnt <= {9'h000, redge};
      else if (redge && wcnt != 10'h3ff) wcnt <= wcnt + 10'h001;
      // The write rearms the count, so a count from before it must not keep wake set.
      if (wr && paddr == `UCS_A_SLEEP) wake <= 1'b0;
      else if (wcnt > actt_reg) wake <= 1'b1;
    end
  end

  // Register writes; hardware sets of flow requests win over clears.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conf0_reg <= `UCS_R_CONF0;
      conf1_reg <= `UCS_R_CONF1;
      swfc_reg <= `UCS_R_SWFC;
      idle_reg <= `UCS_R_IDLE;
      rs485_reg <= 32'h00000000;
      cmd_reg <= `UCS_R_CMD;
      flow_reg <= 6'h00;
      actt_reg <= 10'h000;
      hold <= 1'b0;
      xoff_sent <= 1'b0;
    end else begin
      if (wr) begin
        case (paddr)
          `UCS_A_CONF0: conf0_reg <= pwdata & `UCS_M_CONF0;
          `UCS_A_CONF1: conf1_reg <= pwdata;
          `UCS_A_SWFC: swfc_reg <= pwdata;
          `UCS_A_IDLE: idle_reg <= pwdata & `UCS_M_IDLE;
          `UCS_A_RS485: rs485_reg <= pwdata & `UCS_M_RS485;
          `UCS_A_CMD: cmd_reg <= pwdata & `UCS_M_CMD;
          `UCS_A_SLEEP: actt_reg <= pwdata[`UCS_ACTT];
          default: ;
        endcase
      end
      // The request being sent clears itself; Xoff goes first.
      if (t_go && flow_reg[`UCS_SXOFF]) flow_reg[`UCS_SXOFF] <= 1'b0;
      else if (t_go && flow_reg[`UCS_SXON]) flow_reg[`UCS_SXON] <= 1'b0;
      if (wr && paddr == `UCS_A_FLOW) flow_reg <= pwdata[5:0];
      if (flow_reg[`UCS_SWEN] && !xoff_sent && rx_cnt > swfc_reg[`UCS_XONT]) begin
        flow_reg[`UCS_SXOFF] <= 1'b1;
        xoff_sent <= 1'b1;
      end else if (flow_reg[`UCS_SWEN] && xoff_sent && rx_cnt < swfc_reg[`UCS_XOFFT]) begin
        flow_reg[`UCS_SXON] <= 1'b1;
        xoff_sent <= 1'b0;
      end
      if (wr && paddr == `UCS_A_FLOW && pwdata[`UCS_FXOFF]) hold <= 1'b0;
      if (rdone && fchar && is_xon) hold <= 1'b0;
      if (wr && paddr == `UCS_A_FLOW && pwdata[`UCS_FXON]) hold <= 1'b1;
      if (rdone && fchar && is_xoff) hold <= 1'b1;
    end
  end

  // Readable state codes.
  function [3:0] enc;
    input [7:0] s;
    input [2:0] i;
    input rx;
    begin
      case (s)
        S_STRT: enc = `UCS_C_STRT;
        S_DAT: enc = `UCS_C_DAT0 + {1'b0, i};
        S_PRTY: enc = `UCS_C_PRTY;
        S_STP1: enc = `UCS_C_STP1;
        S_STP2: enc = `UCS_C_STP2;
        S_DL0: enc = `UCS_C_TDL0;
        S_DL1: enc = rx ? `UCS_C_RDL1 : `UCS_C_TDL1;
        default: enc = `UCS_C_IDLE;
      endcase
    end
  endfunction

  // Read multiplexer; an unmapped address answers with an error.
  always @* begin
    hit = 1'b1;
    case (paddr)
      `UCS_A_DATA: rdata = {24'h000000, f_dout[15:8]};
      `UCS_A_STAT: rdata = {enc(tst, tbit, 1'b0), 1'b0, 3'h0, tx_cnt,
        enc(rst_s, rbit, 1'b1), 1'b0, 3'h0, rx_cnt};
      `UCS_A_CONF0: rdata = conf0_reg;
      `UCS_A_CONF1: rdata = conf1_reg;
      `UCS_A_LOWP: rdata = {12'h000, lmin};
      `UCS_A_HIGHP: rdata = {12'h000, hmin};
      `UCS_A_EDGE: rdata = {22'h000000, ecnt};
      `UCS_A_FLOW: rdata = {26'h0000000, flow_reg};
      `UCS_A_SLEEP: rdata = {wake, rin, cts_act, dsr_act, perr, ferr, 16'h0000, actt_reg};
      `UCS_A_SWFC: rdata = swfc_reg;
      `UCS_A_IDLE: rdata = idle_reg;
      `UCS_A_RS485: rdata = rs485_reg;
      `UCS_A_CMD: rdata = cmd_reg;
      default: begin
        rdata = 32'h00000000;
        hit = 1'b0;
      end
    endcase
  end

  // Bus answer and registered line and event outputs.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      txd <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      txfifo_empty_raw <= 1'b0;
      rxfifo_full_raw <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h00000000 : rdata;
        pslverr <= ~hit;
      end
      txd <= tline;
      rts_n <= ~(conf1_reg[`UCS_FLOWEN] ? conf0_reg[`UCS_SWRTS] :
        (rx_cnt <= {1'b0, conf1_reg[`UCS_FLOWT]})) ^ conf0_reg[`UCS_RTSINV];
      dtr_n <= ~conf0_reg[`UCS_SWDTR] ^ conf0_reg[`UCS_DTRINV];
      txfifo_empty_raw <= tx_cnt < conf1_reg[`UCS_EMPTT];
      rxfifo_full_raw <= rx_cnt > conf1_reg[`UCS_FULLT];
    end
  end
endmodule // ucs_uart_config_status_core
`default_nettype wire
